// >>> hdl/netsrc_map.vh
// constants for the network command source selection block
// assumes a single 200 MHz clock and a synchronous active-low reset
//
// Overview of operation
// - separate operation and speed sources, own parameters
// - run permit taken from terminals only
// - thermal relay taken from terminals only
// - forward run from network or terminals
// - reverse run from network or terminals
// - jog ignored in network, terminals otherwise
// - terminal 4 select ignored or combined
// - self-hold ignored in network, terminals otherwise
// - brake release done from network or terminals
// - ext/net switchover from terminals only
// - combined functions accept either path
// - no-source functions ignore both paths
// - network path parameter picks PU or option link
// - write permit 2 allows writes while running
// - new operation and speed source settings apply only when stopped, the network path at once
// - switchover input enabled by code 67 assignment
// - unassigned switchover: sources follow parameters
// - switchover off forces terminals for both
// - switchover input sampled only while stopped
// - switchover off rejects network reset requests
`ifndef NETSRC_MAP_VH
`define NETSRC_MAP_VH

// -----------------------------------------------------------------
// parameter encodings
// -----------------------------------------------------------------
`define OP_SRC_NET 1'h0
`define OP_SRC_EXT 1'h1
`define SPD_SRC_NET 2'h0
`define SPD_SRC_EXT1 2'h1
`define SPD_SRC_EXT2 2'h2
`define WRITE_PERMIT_RUN 2'h2
`define PATH_PU 1'h0
`define PATH_OPTION 1'h1

// -----------------------------------------------------------------
// input terminal function codes
// -----------------------------------------------------------------
`define FN_AN4_SEL 7'h04
`define FN_JOG 7'h05
`define FN_THERMAL 7'h07
`define FN_RUN_PERMIT 7'h0A
`define FN_BRAKE_DONE 7'h0F
`define FN_SELF_HOLD 7'h19
`define FN_FWD 7'h3C
`define FN_REV 7'h3D
`define FN_FAULT_CLR 7'h3E
`define FN_EXT_NET_SW 7'h42
`define FN_SRC_SWITCH 7'h43
`define FN_WIDTH 7

`endif

// >>> hdl/source_latch.v
// stopped-only update holder for the selected sources
// assumes stopped is a clean level from the drive sequencer
`timescale 1ns/100ps
module source_latch #(
  parameter WIDTH = 3
) (
  input wire clk,
  input wire nrst,
  input wire stopped,
  input wire [WIDTH-1:0] req,
  input wire [WIDTH-1:0] rst_val,
  output wire [WIDTH-1:0] held
);
  reg [WIDTH-1:0] held_reg;
  reg [WIDTH-1:0] held_next;

  // -----------------------------------------------------------------
  // hold last value while running
  // -----------------------------------------------------------------
  // a running drive must not see its command source change under it
  always @* begin
    held_next = held_reg;
    if (stopped) begin
      held_next = req;
    end
  end

  // reset value arrives via port but is only taken on a clocked edge
  always @(posedge clk) begin
    if (!nrst) begin
      held_reg <= rst_val;
    end else begin
      held_reg <= held_next;
    end
  end

  assign held = held_reg;
endmodule // source_latch

// >>> hdl/assign_scan.v
// finds whether any input terminal carries a given function code
// assumes assignment codes are packed, one FN_WIDTH field per terminal
`timescale 1ns/100ps
`include "netsrc_map.vh"
module assign_scan #(
  parameter TERMS = 7
) (
  input wire [TERMS*`FN_WIDTH-1:0] assign_codes,
  input wire [`FN_WIDTH-1:0] code,
  input wire [TERMS-1:0] term_level,
  output reg found,
  output reg level
);
  integer i;

  // -----------------------------------------------------------------
  // or-reduce the terminals that carry the code
  // -----------------------------------------------------------------
  always @* begin
    found = 1'b0;
    level = 1'b0;
    for (i = 0; i < TERMS; i = i + 1) begin
      if (assign_codes[i*`FN_WIDTH +: `FN_WIDTH] == code) begin
        found = 1'b1;
        level = level | term_level[i];
      end
    end
  end
endmodule // assign_scan

// >>> hdl/network_command_source_select.v
// network mode command source selection for one drive
// assumes terminal functions are decoded upstream into per-function levels,
// communication commands arrive from both PU and option links, all synchronous to clk
`timescale 1ns/100ps
`include "netsrc_map.vh"
module network_command_source_select #(
  parameter TERMS = 7
) (
  input wire clk,
  input wire nrst,
  // drive state and parameters
  input wire stopped,
  input wire network_mode,
  input wire [1:0] write_permit_param,
  input wire param_write,
  input wire operation_source_param,
  input wire [1:0] speed_source_param,
  input wire net_operation_path_param,
  input wire pu_operation_path_param,
  input wire [TERMS*`FN_WIDTH-1:0] input_assign_params,
  input wire [TERMS-1:0] term_levels,
  // terminal side function levels
  input wire run_permit_input,
  input wire thermal_relay_input,
  input wire forward_run_input,
  input wire reverse_run_input,
  input wire fault_clear_input,
  input wire jog_select_input,
  input wire analog_in4_select,
  input wire self_hold_input,
  input wire brake_release_done_input,
  input wire ext_net_switch_input,
  // communication side from the PU connector
  input wire pu_forward,
  input wire pu_reverse,
  input wire pu_reset_req,
  input wire pu_an4_select,
  input wire pu_brake_done,
  // communication side from the option
  input wire opt_forward,
  input wire opt_reverse,
  input wire opt_reset_req,
  input wire opt_an4_select,
  input wire opt_brake_done,
  // resolved function outputs
  output reg run_permit,
  output reg thermal_trip,
  output reg forward_run,
  output reg reverse_run,
  output reg fault_clear,
  output reg jog_select,
  output reg an4_select,
  output reg self_hold,
  output reg brake_done,
  output reg ext_net_switch,
  output reg op_from_network,
  output reg speed_from_network,
  output reg write_refused,
  output reg net_reset_refused
);
  // -----------------------------------------------------------------
  // declarations
  // -----------------------------------------------------------------
  wire sw_assigned;
  wire sw_level;
  wire [2:0] held_src;
  wire [2:0] sw_held;
  reg op_param_reg;
  reg op_param_next;
  reg [1:0] spd_param_reg;
  reg [1:0] spd_param_next;
  reg net_path_reg;
  reg net_path_next;
  reg eff_op_net;
  reg eff_spd_net;
  reg c_fwd;
  reg c_rev;
  reg c_rst;
  reg c_an4;
  reg c_brk;
  reg run_permit_next;
  reg thermal_next;
  reg fwd_next;
  reg rev_next;
  reg clr_next;
  reg jog_next;
  reg an4_next;
  reg hold_next;
  reg brk_next;
  reg sw_next;
  reg refused_next;
  reg rst_refused_next;

  // route one function by a source flag
  function route;
    input use_net;
    input term_v;
    input net_v;
    begin
      route = use_net ? net_v : term_v;
    end
  endfunction

  // -----------------------------------------------------------------
  // switchover terminal lookup
  // -----------------------------------------------------------------
  assign_scan #(
    .TERMS(TERMS)
  ) u_scan (
    .assign_codes(input_assign_params),
    .code(`FN_SRC_SWITCH),
    .term_level(term_levels),
    .found(sw_assigned),
    .level(sw_level)
  );

  // -----------------------------------------------------------------
  // parameter shadow copies
  // -----------------------------------------------------------------
  // writes while running only pass with write permit 2
  always @* begin
    op_param_next = op_param_reg;
    spd_param_next = spd_param_reg;
    net_path_next = net_path_reg;
    refused_next = 1'b0;
    if (param_write) begin
      if (stopped || write_permit_param == `WRITE_PERMIT_RUN) begin
        op_param_next = operation_source_param;
        spd_param_next = speed_source_param;
        net_path_next = net_operation_path_param;
      end else begin
        refused_next = 1'b1;
      end
    end
  end

  always @(posedge clk) begin
    if (!nrst) begin
      op_param_reg <= `OP_SRC_NET;
      spd_param_reg <= `SPD_SRC_NET;
      net_path_reg <= `PATH_OPTION;
    end else begin
      op_param_reg <= op_param_next;
      spd_param_reg <= spd_param_next;
      net_path_reg <= net_path_next;
    end
  end

  // -----------------------------------------------------------------
  // stopped-only application
  // -----------------------------------------------------------------
  source_latch #(
    .WIDTH(3)
  ) u_param_hold (
    .clk(clk),
    .nrst(nrst),
    .stopped(stopped),
    .req({op_param_reg, spd_param_reg}),
    .rst_val({`OP_SRC_NET, `SPD_SRC_NET}),
    .held(held_src)
  );

  // bit 2 assigned, bit 1 level, bit 0 unused spare
  source_latch #(
    .WIDTH(3)
  ) u_sw_hold (
    .clk(clk),
    .nrst(nrst),
    .stopped(stopped),
    .req({sw_assigned, sw_level, 1'b0}),
    .rst_val(3'h0),
    .held(sw_held)
  );

  // -----------------------------------------------------------------
  // effective sources
  // -----------------------------------------------------------------
  // outside network mode both the operation and the speed source are forced to the terminals
  always @* begin
    eff_op_net = held_src[2] == `OP_SRC_NET;
    eff_spd_net = held_src[1:0] == `SPD_SRC_NET;
    if (sw_held[2] && !sw_held[1]) begin
      eff_op_net = 1'b0;
      eff_spd_net = 1'b0;
    end
    // switch on: parameters stand as they are
    if (sw_held[2] && sw_held[1]) begin
      eff_op_net = held_src[2] == `OP_SRC_NET;
      eff_spd_net = held_src[1:0] == `SPD_SRC_NET;
    end
    if (!network_mode) begin
      eff_op_net = 1'b0;
      eff_spd_net = 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // communication path choice
  // -----------------------------------------------------------------
  // pu path param is carried for the PU mode decision made elsewhere
  always @* begin
    if (net_path_reg == `PATH_PU) begin
      c_fwd = pu_forward;
      c_rev = pu_reverse;
      c_rst = pu_reset_req;
      c_an4 = pu_an4_select;
      c_brk = pu_brake_done;
    end else begin
      c_fwd = opt_forward;
      c_rev = opt_reverse;
      c_rst = opt_reset_req;
      c_an4 = opt_an4_select;
      c_brk = opt_brake_done;
    end
  end

  // -----------------------------------------------------------------
  // per-function routing
  // -----------------------------------------------------------------
  always @* begin
    run_permit_next = run_permit_input;
    thermal_next = thermal_relay_input;
    fwd_next = route(eff_op_net, forward_run_input, c_fwd);
    rev_next = route(eff_op_net, reverse_run_input, c_rev);
    clr_next = fault_clear_input;
    // no source in network: both paths dropped
    jog_next = eff_op_net ? 1'b0 : jog_select_input;
    hold_next = eff_op_net ? 1'b0 : self_hold_input;
    // combined once speed source is external
    an4_next = eff_spd_net ? 1'b0 : (analog_in4_select | c_an4);
    brk_next = route(eff_op_net, brake_release_done_input, c_brk);
    sw_next = ext_net_switch_input;
    rst_refused_next = network_mode && sw_held[2] && !sw_held[1] && c_rst;
  end

  // -----------------------------------------------------------------
  // registered outputs
  // -----------------------------------------------------------------
  always @(posedge clk) begin
    if (!nrst) begin
      run_permit <= 1'b0;
      thermal_trip <= 1'b0;
      forward_run <= 1'b0;
      reverse_run <= 1'b0;
      fault_clear <= 1'b0;
      jog_select <= 1'b0;
      an4_select <= 1'b0;
      self_hold <= 1'b0;
      brake_done <= 1'b0;
      ext_net_switch <= 1'b0;
      op_from_network <= 1'b0;
      speed_from_network <= 1'b0;
      write_refused <= 1'b0;
      net_reset_refused <= 1'b0;
    end else begin
      run_permit <= run_permit_next;
      thermal_trip <= thermal_next;
      forward_run <= fwd_next;
      reverse_run <= rev_next;
      fault_clear <= clr_next;
      jog_select <= jog_next;
      an4_select <= an4_next;
      self_hold <= hold_next;
      brake_done <= brk_next;
      ext_net_switch <= sw_next;
      op_from_network <= eff_op_net;
      speed_from_network <= eff_spd_net;
      write_refused <= refused_next;
      net_reset_refused <= rst_refused_next;
    end
  end
endmodule // network_command_source_select

// >>> sim/ncss_props.sv
// checker for the network command source select block
// assumes it is bound to the block top and sees only its ports
`timescale 1ns/100ps
`include "netsrc_map.vh"
module ncss_props #(
  parameter TERMS = 7
) (
  input wire clk,
  input wire nrst,
  input wire stopped,
  input wire network_mode,
  input wire [1:0] write_permit_param,
  input wire param_write,
  input wire [TERMS-1:0] term_levels,
  input wire run_permit_input,
  input wire thermal_relay_input,
  input wire forward_run_input,
  input wire fault_clear_input,
  input wire ext_net_switch_input,
  input wire run_permit,
  input wire thermal_trip,
  input wire forward_run,
  input wire fault_clear,
  input wire jog_select,
  input wire an4_select,
  input wire self_hold,
  input wire ext_net_switch,
  input wire op_from_network,
  input wire speed_from_network,
  input wire write_refused,
  input wire net_reset_refused
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // $past(nrst) guard: outputs are held at 0 on the first edge out of reset
  chk_permit_term: assert property ($past(nrst) |-> run_permit == $past(run_permit_input))
    else $error("run permit not from terminal");
  chk_thermal_term: assert property ($past(nrst) |-> thermal_trip == $past(thermal_relay_input))
    else $error("thermal trip not from terminal");
  chk_fault_term: assert property ($past(nrst) |-> fault_clear == $past(fault_clear_input))
    else $error("fault clear not from terminal");
  chk_extnet_term: assert property ($past(nrst) |-> ext_net_switch == $past(ext_net_switch_input))
    else $error("ext net switch not from terminal");
  chk_fwd_term: assert property ($past(nrst) && !op_from_network |-> forward_run == $past(forward_run_input))
    else $error("forward run not from terminal");
  chk_jog_ignored: assert property (jog_select |-> !op_from_network)
    else $error("jog passed with network operation source");
  chk_hold_ignored: assert property (self_hold |-> !op_from_network)
    else $error("self hold passed with network operation source");
  chk_an4_ignored: assert property (an4_select |-> !speed_from_network)
    else $error("an4 select passed with network speed source");
  chk_write_refused: assert property (param_write && !stopped && write_permit_param != `WRITE_PERMIT_RUN
    |-> ##[1:2] write_refused)
    else $error("running write not refused");
  chk_run_hold: assert property ((!stopped && $stable(network_mode) && $stable(term_levels)) [*3]
    |-> $stable(op_from_network) && $stable(speed_from_network))
    else $error("sources changed while running");
  chk_reset_block: assert property (net_reset_refused |-> !op_from_network && !speed_from_network)
    else $error("reset refused without terminal sources");
  cov_refused: cover property (write_refused);
  cov_reset_block: cover property (net_reset_refused);
  cov_run_net: cover property (!stopped && op_from_network);
endmodule // ncss_props
bind network_command_source_select ncss_props #(.TERMS(TERMS)) u_props (.clk, .nrst, .stopped, .network_mode,
  .write_permit_param, .param_write, .term_levels, .run_permit_input, .thermal_relay_input, .forward_run_input,
  .fault_clear_input, .ext_net_switch_input, .run_permit, .thermal_trip, .forward_run, .fault_clear, .jog_select,
  .an4_select, .self_hold, .ext_net_switch, .op_from_network, .speed_from_network, .write_refused,
  .net_reset_refused);

// >>> sim/net_partner.sv
// far side stand-in: terminal function lines and both link masters
// assumes the block samples these lines on the rising edge only
`timescale 1ns/100ps
module net_partner (
  input wire clk,
  input wire en,
  output reg [19:0] lines
);
  // ----------------------------------------
  // stimulus
  // ----------------------------------------
  // fresh levels each falling edge so a stale value never passes
  // seeded in the drawing process itself: each process has its own generator
  initial begin
    lines = 20'h00000;
    void'($urandom(32'h22E2AF9C));
    forever begin
      @(negedge clk);
      if (en) lines <= 20'($urandom);
    end
  end
endmodule // net_partner

// >>> sim/network_command_source_select_tb_top.sv
// self-checking bench for the network command source select block
// assumes the checker is bound in and the partner drives all function lines
`timescale 1ns/100ps
`include "netsrc_map.vh"
`define CMP(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module network_command_source_select_tb_top;
  reg clk = 0, nrst = 0, stopped = 1, nm = 1, pw = 0, op = 0, path = 0, seen = 0;
  reg [1:0] perm = 0, spd = 0;
  reg [48:0] asg = 0;
  reg [6:0] lv = 0;
  reg e_op = 1, e_spd = 1, e_path = 1, sw_off = 0, chk_on = 0;
  reg [12:0] ev;
  reg [12:0] q[$];
  integer errors = 0, cmp_count = 0, cyc = 0;
  wire [19:0] ln;
  wire [12:0] got;
  wire wref;
  // ----------------------------------------
  // block and far side
  // ----------------------------------------
  network_command_source_select #(.TERMS(7)) dut (.clk(clk), .nrst(nrst), .stopped(stopped), .network_mode(nm),
    .write_permit_param(perm), .param_write(pw), .operation_source_param(op), .speed_source_param(spd),
    .net_operation_path_param(path), .pu_operation_path_param(1'b0), .input_assign_params(asg),
    .term_levels(lv), .run_permit_input(ln[0]), .thermal_relay_input(ln[1]), .forward_run_input(ln[2]),
    .reverse_run_input(ln[3]), .fault_clear_input(ln[4]), .jog_select_input(ln[5]), .analog_in4_select(ln[6]),
    .self_hold_input(ln[7]), .brake_release_done_input(ln[8]), .ext_net_switch_input(ln[9]),
    .pu_forward(ln[10]), .pu_reverse(ln[11]), .pu_reset_req(ln[12]), .pu_an4_select(ln[13]),
    .pu_brake_done(ln[14]), .opt_forward(ln[15]), .opt_reverse(ln[16]), .opt_reset_req(ln[17]),
    .opt_an4_select(ln[18]), .opt_brake_done(ln[19]), .run_permit(got[12]), .thermal_trip(got[11]),
    .forward_run(got[10]), .reverse_run(got[9]), .fault_clear(got[8]), .jog_select(got[7]),
    .an4_select(got[6]), .self_hold(got[5]), .brake_done(got[4]), .ext_net_switch(got[3]),
    .op_from_network(got[2]), .speed_from_network(got[1]), .write_refused(wref), .net_reset_refused(got[0]));
  net_partner u_far (.clk(clk), .en(1'b1), .lines(ln));
  // ----------------------------------------
  // expectation and scoreboard
  // ----------------------------------------
  // routing from the bench's own idea of the sources in force
  function [12:0] expv(input [19:0] l);
    reg [4:0] c;
    reg eo, es;
    begin
      c = e_path ? l[19:15] : l[14:10];
      eo = nm & e_op & !sw_off;
      es = nm & e_spd & !sw_off;
      expv = {l[0], l[1], eo ? c[0] : l[2], eo ? c[1] : l[3], l[4], !eo & l[5], !es & (l[6] | c[3]),
        !eo & l[7], eo ? c[4] : l[8], l[9], eo, es, nm & sw_off & c[2]};
    end
  endfunction
  initial forever #2.5 clk = ~clk;
  // note at each sampling edge, hang guard too
  always @(posedge clk) begin
    cyc++;
    if (chk_on) q.push_back(expv(ln));
    if (cyc > 2000) begin
      errors++;
      give_verdict;
    end
  end
  // one cycle answer, so compare on the following falling edge
  always @(negedge clk) begin
    if (q.size() > 0) begin
      ev = q.pop_front();
      `CMP(got, ev)
    end
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  // settle past the write and switch pipelines before checking
  task run;
    begin
      repeat (6) @(negedge clk);
      chk_on = 1;
      repeat (40) @(negedge clk);
      chk_on = 0;
      repeat (2) @(negedge clk);
    end
  endtask
  task wr(input o, input [1:0] s, input p, input r);
    begin
      op = o;
      spd = s;
      path = p;
      pw = 1;
      seen = 0;
      // the refusal pulse stands only between the two edges after the write
      @(negedge clk) pw = 0;
      seen = wref;
      repeat (2) @(negedge clk) seen = seen | wref;
      `CMP(seen, r)
    end
  endtask
  task give_verdict;
    begin
      $display("errors=%0d compares=%0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    @(negedge clk) nrst = 1;
    run;
    e_op = 0; e_spd = 0; e_path = 0;
    wr(1'b1, 2'h1, 1'b0, 1'b0); run;
    e_op = 1;
    wr(1'b0, 2'h2, 1'b0, 1'b0); run;
    e_op = 0; e_spd = 1; e_path = 1;
    wr(1'b1, 2'h0, 1'b1, 1'b0); run;
    stopped = 0;
    wr(1'b0, 2'h0, 1'b0, 1'b1); run;
    perm = `WRITE_PERMIT_RUN;
    wr(1'b0, 2'h0, 1'b0, 1'b0); run;
    stopped = 1; e_op = 1; e_path = 0; run;
    asg[27:21] = `FN_SRC_SWITCH; sw_off = 1; run;
    lv = 7'h08; sw_off = 0; run;
    stopped = 0; lv = 7'h00; run;
    stopped = 1; sw_off = 1; run;
    asg = 0; sw_off = 0; nm = 0; run;
    give_verdict;
  end
endmodule // network_command_source_select_tb_top
